// ### asx_pkg.sv
package asx_pkg;
   // ************************************************************
   // register map (offsets chosen for this block)
   // ************************************************************
   localparam logic [3:0] ADDR_EXT0    = 4'h0;  // extension control ch0
   localparam logic [3:0] ADDR_EXT1    = 4'h1;  // extension control ch1
   localparam logic [3:0] ADDR_CHANNEL0_STATUS_REG   = 4'h2;  // channel 0 status
   localparam logic [3:0] ADDR_CTLB0   = 4'h3;  // control b ch0
   localparam logic [3:0] ADDR_CTLB1   = 4'h4;  // control b ch1
   localparam logic [3:0] ADDR_TC0     = 4'h5;  // time constant ch0
   localparam logic [3:0] ADDR_TC1     = 4'h6;  // time constant ch1
   localparam logic [3:0] ADDR_IRQ_ST  = 4'h7;  // sticky events
   localparam logic [3:0] ADDR_IRQ_MSK = 4'h8;  // event mask
   localparam logic [3:0] ADDR_CTLA    = 4'h9;  // control a (efr pulse)

   // ************************************************************
   // extension control field positions
   // ************************************************************
   localparam int EXT_SEND_BRK  = 0;
   localparam int EXT_BRK_DET   = 1;
   localparam int EXT_BRK_EN    = 2;
   localparam int EXT_BRG_MODE  = 3;
   localparam int EXT_UNITY     = 4;
   localparam int EXT_CTS_OFF   = 5;
   localparam int EXT_CARR_OFF  = 6;

   // status / control b / control a fields
   localparam int ST0_TX_EMPTY  = 1;
   localparam int ST0_CARRIER   = 2;
   localparam int CTLB_CTS      = 5;
   localparam int CTLB_DIV_RAT  = 4;
   localparam int CTLB_SS_LO    = 0;
   localparam int CTLA_EFR      = 3;

   // ************************************************************
   // reset values and divider figures
   // ************************************************************
   localparam logic [7:0]  EXT_RESET   = 8'h00;
   localparam logic [7:0]  CTLB_RESET  = 8'h07;
   localparam logic [15:0] TC_RESET    = 16'h0000;
   localparam logic [2:0]  SS_EXTERNAL = 3'h7;
   localparam logic [5:0]  PRE_DIV_LO  = 6'h0a;  // divide by 10
   localparam logic [5:0]  PRE_DIV_HI  = 6'h1e;  // divide by 30
   localparam logic [6:0]  OVS_LO      = 7'h10;  // x16
   localparam logic [6:0]  OVS_HI      = 7'h40;  // x64
   localparam logic [16:0] TC_OFFSET   = 17'h00002;
endpackage

// ### asx_ext_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - carrier high holds ch0 receiver in reset
// - carrier ignored when its autoenable is off
// - carrier level readable; rising edge interrupts
// - cts high forces ch0 tx holding empty low
// - cts ignored when off; level readable
// - unity mode uses bit clock directly
// - otherwise divide bit clock by 16/64
// - legacy generator: 10/30 then power of two
// - tc generator: divide by 2*(tc+2)
// - break functions only while break enabled
// - zero char with framing error sets detect
// - detect clears on efr, stop, ch0 carrier loss
// - send break drives serial output low
// - extension registers reset to zero
// - carrier status clears on read after fall
module asx_ext_ctrl (
   input  wire logic       core_clk_i,       // system clock 20 MHz
   input  wire logic       rst_i,            // sync reset, high
   input  wire logic [3:0] reg_addr_i,       // register address
   input  wire logic [7:0] reg_wdata_i,      // write data
   input  wire logic       reg_wr_i,         // write strobe
   input  wire logic       reg_rd_i,         // read strobe
   output logic      [7:0] reg_rdata_o,      // read data, next cycle
   input  wire logic       io_stop_mode_i,   // io stop mode level
   input  wire logic       carrier_sel_i,    // pin muxed to carrier
   input  wire logic       cts_sel_i,        // pin muxed to cts
   input  wire logic       carrier_detect_in_i, // pin, active low
   input  wire logic       clear_to_send_in_i,  // pin, active low
   input  wire logic [1:0] serial_clock_pin_i,  // ext bit clocks
   input  wire logic [1:0] tx_serial_i,      // transmitter data
   input  wire logic [1:0] tx_hold_empty_i,  // raw holding empty
   input  wire logic [1:0] rx_head_valid_i,  // new oldest fifo entry
   input  wire logic [1:0] rx_head_zero_i,   // head char is all zero
   input  wire logic [1:0] rx_head_ferr_i,   // head framing error
   output logic      [1:0] serial_tx_out_o,  // serial outputs
   output logic      [1:0] tx_holding_empty_o, // gated empty flag
   output logic      [1:0] rx_reset_o,       // receiver held in reset
   output logic      [1:0] bit_tick_o,       // one pulse per bit
   output logic      [1:0] brg_clk_o,        // generator clock out
   output logic            irq_o             // level interrupt
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic       dcd_s1_q, dcd_s2_q, dcd_s3_q;  // carrier sync chain
   logic       cts_s1_q, cts_s2_q;            // cts sync chain
   logic [1:0] ck_s1_q, ck_s2_q, ck_s3_q;     // serial clock sync

   // two stages then one more for edge detection off stage two
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         dcd_s1_q <= 1'b1;
         dcd_s2_q <= 1'b1;
         dcd_s3_q <= 1'b1;
         cts_s1_q <= 1'b1;
         cts_s2_q <= 1'b1;
         ck_s1_q  <= 2'h3;  // idle high like the pin, no false edge
         ck_s2_q  <= 2'h3;
         ck_s3_q  <= 2'h3;
      end else begin
         dcd_s1_q <= carrier_detect_in_i;
         dcd_s2_q <= dcd_s1_q;
         dcd_s3_q <= dcd_s2_q;
         cts_s1_q <= clear_to_send_in_i;
         cts_s2_q <= cts_s1_q;
         ck_s1_q  <= serial_clock_pin_i;
         ck_s2_q  <= ck_s1_q;
         ck_s3_q  <= ck_s2_q;
      end
   end

   // ************************************************************
   // register storage
   // ************************************************************
   logic [7:0]  ext_q   [2];   // extension control per channel
   logic [7:0]  ctlb_q  [2];   // control b per channel
   logic [15:0] tc_q    [2];   // time constant per channel
   logic [1:0]  brk_det_q;     // break detect flags
   logic        carr_st_q;     // carrier status flag
   logic        carr_fell_q;   // fall seen, clear on next read
   logic [1:0]  irq_st_q;      // sticky: 0 carrier rise, 1 break
   logic [1:0]  irq_msk_q;     // interrupt mask
   logic [7:0]  rdata_q;       // read data register

   logic wr_efr;               // control a written with efr zero
   logic carr_auto;            // carrier autoenable is active
   logic cts_auto;             // cts autoenable is active
   logic carr_rise, carr_fall; // synced carrier edges
   logic st_rd, irq_rd;        // status / event register reads
   assign wr_efr    = reg_wr_i && reg_addr_i == asx_pkg::ADDR_CTLA &&
                      !reg_wdata_i[asx_pkg::CTLA_EFR];
   assign carr_auto = carrier_sel_i &&
                      !ext_q[0][asx_pkg::EXT_CARR_OFF];
   assign cts_auto  = cts_sel_i && !ext_q[0][asx_pkg::EXT_CTS_OFF];
   assign carr_rise = dcd_s2_q && !dcd_s3_q;
   assign carr_fall = !dcd_s2_q && dcd_s3_q;
   assign st_rd     = reg_rd_i && reg_addr_i == asx_pkg::ADDR_CHANNEL0_STATUS_REG;
   assign irq_rd    = reg_rd_i && reg_addr_i == asx_pkg::ADDR_IRQ_ST;

   // software writable registers; extension ch1 stores bits 5:0 only
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ext_q[0]  <= asx_pkg::EXT_RESET;
         ext_q[1]  <= asx_pkg::EXT_RESET;
         ctlb_q[0] <= asx_pkg::CTLB_RESET;
         ctlb_q[1] <= asx_pkg::CTLB_RESET;
         tc_q[0]   <= asx_pkg::TC_RESET;
         tc_q[1]   <= asx_pkg::TC_RESET;
         irq_msk_q <= 2'h0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            asx_pkg::ADDR_EXT0: begin
               ext_q[0] <= reg_wdata_i;
            end
            asx_pkg::ADDR_EXT1: begin
               ext_q[1] <= {2'h0, reg_wdata_i[5:0]};
            end
            asx_pkg::ADDR_CTLB0: begin
               ctlb_q[0] <= reg_wdata_i;
            end
            asx_pkg::ADDR_CTLB1: begin
               ctlb_q[1] <= reg_wdata_i;
            end
            // time constant: old low byte shifts to high byte, write goes to low byte
            asx_pkg::ADDR_TC0: begin
               tc_q[0] <= {tc_q[0][7:0], reg_wdata_i};
            end
            asx_pkg::ADDR_TC1: begin
               tc_q[1] <= {tc_q[1][7:0], reg_wdata_i};
            end
            asx_pkg::ADDR_IRQ_MSK: begin
               irq_msk_q <= reg_wdata_i[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // carrier status flag
   // ************************************************************
   // high follows pin; low only after a status read past the fall
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         carr_st_q   <= 1'b0;
         carr_fell_q <= 1'b0;
      end else if (dcd_s2_q) begin
         carr_st_q   <= 1'b1;
         carr_fell_q <= 1'b0;
      end else begin
         if (carr_fall) begin
            carr_fell_q <= 1'b1;
         end else if (st_rd && carr_fell_q) begin
            carr_st_q   <= 1'b0;
            carr_fell_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // per channel break, divider and output logic
   // ************************************************************
   logic [1:0] brk_set;    // break detect set condition
   logic [1:0] brk_clr;    // break detect clear condition

   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [5:0]  pre_cnt_q;   // legacy 10/30 prescaler
      logic [7:0]  pow_cnt_q;   // power of two stage; index 7 legal
      logic [16:0] tc_cnt_q;    // time constant half-period count
      logic        brg_q;       // generator output level
      logic [6:0]  ovs_cnt_q;   // 16/64 oversample count
      logic        tick_q;      // bit tick register
      logic        tx_q;        // registered serial output
      logic        src_edge;    // selected bit clock rising edge
      logic        brg_edge;    // external pin rising edge this cycle
      logic [2:0]  ss;
      logic [7:0]  ext;

      assign ss  = ctlb_q[c][asx_pkg::CTLB_SS_LO +: 3];
      assign ext = ext_q[c];

      // legacy chain: prescale 10/30 then 2^(ss+1); tc chain toggles
      always_ff @(posedge core_clk_i) begin
         if (rst_i) begin
            pre_cnt_q <= 6'h00;
            pow_cnt_q <= 8'h00;
            tc_cnt_q  <= 17'h00000;
            brg_q     <= 1'b0;
         end else if (ext[asx_pkg::EXT_BRG_MODE]) begin
            // toggle every tc+2 cycles: period 2*(tc+2)
            if (tc_cnt_q + 17'h00001 >=
                {1'b0, tc_q[c]} + asx_pkg::TC_OFFSET) begin
               tc_cnt_q <= 17'h00000;
               brg_q    <= !brg_q;
            end else begin
               tc_cnt_q <= tc_cnt_q + 17'h00001;
            end
         end else begin
            if (pre_cnt_q + 6'h01 >=
                (ctlb_q[c][asx_pkg::CTLB_DIV_RAT] ?
                 asx_pkg::PRE_DIV_HI : asx_pkg::PRE_DIV_LO)) begin
               pre_cnt_q <= 6'h00;
               pow_cnt_q <= pow_cnt_q + 8'h01;
            end else begin
               pre_cnt_q <= pre_cnt_q + 6'h01;
            end
            // output is bit ss of power counter: divide by 2^(ss+1)
            brg_q <= pow_cnt_q[ss];
         end
      end

      // edge of generator or external pin when ss selects it
      assign brg_edge = (ss == asx_pkg::SS_EXTERNAL) ?
                        (ck_s2_q[c] && !ck_s3_q[c]) : 1'b0;
      logic brg_d1_q;
      always_ff @(posedge core_clk_i) begin
         if (rst_i) begin
            brg_d1_q <= 1'b0;
         end else begin
            brg_d1_q <= brg_q;
         end
      end
      assign src_edge = brg_edge ||
                        (ss != asx_pkg::SS_EXTERNAL && brg_q && !brg_d1_q);

      // unity mode passes edges, else 16/64 oversample divide
      always_ff @(posedge core_clk_i) begin
         if (rst_i) begin
            ovs_cnt_q <= 7'h00;
            tick_q    <= 1'b0;
         end else if (ext[asx_pkg::EXT_UNITY]) begin
            ovs_cnt_q <= 7'h00;
            tick_q    <= src_edge;
         end else if (src_edge) begin
            if (ovs_cnt_q + 7'h01 >=
                (ctlb_q[c][asx_pkg::CTLB_DIV_RAT] ?
                 asx_pkg::OVS_HI : asx_pkg::OVS_LO)) begin
               ovs_cnt_q <= 7'h00;
               tick_q    <= 1'b1;
            end else begin
               ovs_cnt_q <= ovs_cnt_q + 7'h01;
               tick_q    <= 1'b0;
            end
         end else begin
            tick_q <= 1'b0;
         end
      end

      // break detect: set wins over clear so no event is lost
      assign brk_set[c] = ext[asx_pkg::EXT_BRK_EN] &&
                          rx_head_valid_i[c] && rx_head_zero_i[c] &&
                          rx_head_ferr_i[c];
      assign brk_clr[c] = wr_efr || io_stop_mode_i ||
                          (c == 0 && carr_auto && dcd_s2_q);
      always_ff @(posedge core_clk_i) begin
         if (rst_i) begin
            brk_det_q[c] <= 1'b0;
         end else if (brk_set[c]) begin
            brk_det_q[c] <= 1'b1;
         end else if (brk_clr[c]) begin
            brk_det_q[c] <= 1'b0;
         end
      end

      // break level held while send break and break enable are both set
      always_ff @(posedge core_clk_i) begin
         if (rst_i) begin
            tx_q <= 1'b1;
         end else if (ext[asx_pkg::EXT_SEND_BRK] &&
                      ext[asx_pkg::EXT_BRK_EN]) begin
            tx_q <= 1'b0;
         end else begin
            tx_q <= tx_serial_i[c];
         end
      end

      assign serial_tx_out_o[c] = tx_q;
      assign bit_tick_o[c]      = tick_q;
      assign brg_clk_o[c]       = brg_q;
   end

   // ************************************************************
   // auto-enables
   // ************************************************************
   // disabled auto-enable leaves pins without effect on rx reset or tx empty
   assign rx_reset_o[0] = carr_auto && dcd_s2_q;
   assign rx_reset_o[1] = 1'b0;
   assign tx_holding_empty_o[0] = tx_hold_empty_i[0] &&
                                  !(cts_auto && cts_s2_q);
   assign tx_holding_empty_o[1] = tx_hold_empty_i[1];

   // ************************************************************
   // interrupts
   // ************************************************************
   // sticky events; a read of the event register clears, a new event wins
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_st_q <= 2'h0;
      end else begin
         // set wins over the clearing read
         irq_st_q <= {|brk_set, carr_rise} |
                     (irq_rd ? 2'h0 : irq_st_q);
      end
   end
   assign irq_o = |(irq_st_q & irq_msk_q);

   // ************************************************************
   // read path
   // ************************************************************
   // data valid only in cycle after strobe; zero otherwise
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !reg_rd_i) begin
         rdata_q <= 8'h00;
      end else begin
         case (reg_addr_i)
            asx_pkg::ADDR_EXT0: begin
               rdata_q <= {ext_q[0][7:2], brk_det_q[0], ext_q[0][0]};
            end
            asx_pkg::ADDR_EXT1: begin
               rdata_q <= {ext_q[1][7:2], brk_det_q[1], ext_q[1][0]};
            end
            asx_pkg::ADDR_CHANNEL0_STATUS_REG: begin
               rdata_q <= {5'h00, carr_st_q, tx_holding_empty_o[0],
                           1'b0};
            end
            asx_pkg::ADDR_CTLB0: begin
               rdata_q <= {ctlb_q[0][7:6], cts_s2_q,
                           ctlb_q[0][4:0]};
            end
            asx_pkg::ADDR_CTLB1: begin
               rdata_q <= ctlb_q[1];
            end
            asx_pkg::ADDR_TC0: begin
               rdata_q <= tc_q[0][7:0];
            end
            asx_pkg::ADDR_TC1: begin
               rdata_q <= tc_q[1][7:0];
            end
            asx_pkg::ADDR_IRQ_ST: begin
               rdata_q <= {6'h00, irq_st_q};
            end
            asx_pkg::ADDR_IRQ_MSK: begin
               rdata_q <= {6'h00, irq_msk_q};
            end
            default: begin
               rdata_q <= 8'h00;
            end
         endcase
      end
   end
   assign reg_rdata_o = rdata_q;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_send_brk;
      ext_q[0][asx_pkg::EXT_SEND_BRK] && ext_q[0][asx_pkg::EXT_BRK_EN];
   endsequence
   rx_hold_a: assert property (
      (carr_auto && $past(carrier_detect_in_i, 2)) |-> rx_reset_o[0])
      else $error("receiver not held while carrier lost");
   carr_off_a: assert property (
      ext_q[0][asx_pkg::EXT_CARR_OFF] |-> !rx_reset_o[0])
      else $error("carrier affects receiver while disabled");
   carr_irq_a: assert property (
      carr_rise |=> irq_st_q[0])
      else $error("carrier rise not flagged");
   cts_gate_a: assert property (
      (cts_auto && $past(clear_to_send_in_i, 2)) |-> !tx_holding_empty_o[0])
      else $error("empty flag not forced low");
   cts_off_a: assert property (
      !cts_auto |-> tx_holding_empty_o[0] == tx_hold_empty_i[0])
      else $error("cts affects tx while disabled");
   brk_gate_a: assert property (
      (!ext_q[0][asx_pkg::EXT_BRK_EN] && !brk_det_q[0]) |=>
      !brk_det_q[0])
      else $error("break detected while disabled");
   brk_set_a: assert property (
      brk_set[0] |=> brk_det_q[0])
      else $error("break detect not set");
   brk_clr_a: assert property (
      (wr_efr && !brk_set[0]) |=> !brk_det_q[0])
      else $error("break detect not cleared");
   brk_tx_a: assert property (
      s_send_brk ##1 s_send_brk |-> !serial_tx_out_o[0])
      else $error("serial output not low during break");
   st_clr_a: assert property (
      (st_rd && carr_fell_q && !dcd_s2_q) |=> !carr_st_q)
      else $error("carrier status not cleared on read");
   ext_rst_a: assert property (
      disable iff (1'b0) rst_i |=> ext_q[0] == 8'h00 && ext_q[1] == 8'h00)
      else $error("extension registers not reset");
endmodule

// ### asx_remote_dev.sv
`timescale 1ns/100ps
// ************************************************************
// far end: modem pins and external bit clock
// ************************************************************
module asx_remote_dev (
   input  wire logic       clk_i,      // system clock
   input  wire logic       run_i,      // bit clock running
   input  wire logic       carr_neg_i, // carrier lost when high
   input  wire logic       cts_neg_i,  // not ready when high
   output logic            carr_o,     // carrier pin, active low
   output logic            cts_o,      // cts pin, active low
   output logic      [1:0] sclk_o      // bit clocks per channel
);
   logic [1:0] ph_q;                   // half period counter

   initial begin
      carr_o = 1'b0;
      cts_o  = 1'b0;
      sclk_o = 2'b11;
      ph_q   = 2'h0;
   end

   // pins move just after an edge, like a real modem
   always @(posedge clk_i) begin
      carr_o <= carr_neg_i;
      cts_o  <= cts_neg_i;
   end

   // clock stands high outside frames, period six cycles
   always @(posedge clk_i) begin
      if (!run_i) begin
         sclk_o <= 2'b11;
         ph_q   <= 2'h0;
      end else if (ph_q == 2'h2) begin
         sclk_o <= ~sclk_o;
         ph_q   <= 2'h0;
      end else begin
         ph_q <= ph_q + 2'h1;
      end
   end
endmodule

// ### asx_ext_ctrl_tb.sv
`timescale 1ns/100ps
module asx_ext_ctrl_tb;
   logic       clk, rst, wr, rd, io_stop_mode, csel, tsel, run, cneg, tneg;
   logic [3:0] addr;                   // register address
   logic [7:0] wd, rdata, v;           // bus data
   logic [1:0] sclk, txs, thei, hv, hz, hf, txo, the, rxr, tick, baud_generator;
   logic       carr, cts, irq;
   int         fail_count, n_checks, n;
   logic [31:0] r;                     // random draw
   // period table: control b, extension, mode
   logic [7:0] tcb [6] = '{8'h00, 8'h11, 8'h00, 8'h10, 8'h00, 8'h07};
   logic [7:0] tex [6] = '{8'h10, 8'h10, 8'h00, 8'h08, 8'h18, 8'h10};
   logic [7:0] brk [4] = '{8'h00, 8'h01, 8'h04, 8'h05};

   asx_ext_ctrl i_asx_ext_ctrl (.core_clk_i(clk), .rst_i(rst),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .io_stop_mode_i(io_stop_mode), .carrier_sel_i(csel),
      .cts_sel_i(tsel), .carrier_detect_in_i(carr),
      .clear_to_send_in_i(cts), .serial_clock_pin_i(sclk),
      .tx_serial_i(txs), .tx_hold_empty_i(thei), .rx_head_valid_i(hv),
      .rx_head_zero_i(hz), .rx_head_ferr_i(hf), .serial_tx_out_o(txo),
      .tx_holding_empty_o(the), .rx_reset_o(rxr), .bit_tick_o(tick),
      .brg_clk_o(baud_generator), .irq_o(irq));
   asx_remote_dev i_asx_remote_dev (.clk_i(clk), .run_i(run),
      .carr_neg_i(cneg), .cts_neg_i(tneg), .carr_o(carr), .cts_o(cts),
      .sclk_o(sclk));

   // ************************************************************
   // clock, bus tasks, checks
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic wrr(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // data stands only in the cycle after the strobe
   task automatic rdr(logic [3:0] a);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic cyc(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // head of fifo event, one cycle pulse on channel 0
   task automatic head(logic z, logic f);
      @(posedge clk);
      hv <= 2'b01; hz <= {1'b0, z}; hf <= {1'b0, f};
      @(posedge clk);
      hv <= 2'b00;
   endtask

   // cycles between two ticks; the first gap is skipped
   task automatic gap(output int c);
      int k;
      k = 0;
      while (tick[0] !== 1'b1 && k < 3000) begin
         @(posedge clk); #1 k++;
      end
      @(posedge clk); #1 c = 1;
      while (tick[0] !== 1'b1 && c < 3000) begin
         @(posedge clk); #1 c++;
      end
   endtask

   // expected bit time in system clocks
   function automatic int per(logic [7:0] cb, logic [7:0] ex, int tc);
      int g, s;
      s = cb[2:0];
      if (s == 7) g = 6;
      else if (ex[3]) g = 2 * (tc + 2);
      else g = (cb[4] ? 30 : 10) << (s + 1);
      return ex[4] ? g : g * (cb[4] ? 64 : 16);
   endfunction

   task automatic close_out;
      if (fail_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // hang guard, well beyond the expected run
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      close_out;
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {wr, rd, io_stop_mode, csel, tsel, run, cneg, tneg} = '0;
      {addr, wd, txs, thei, hv, hz, hf} = '0;
      fail_count = 0; n_checks = 0; rst = 1'b1;
      r = $urandom(76);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rdr(asx_pkg::ADDR_EXT0); chk("ext0", 8'h00, v);
      rdr(asx_pkg::ADDR_EXT1); chk("ext1", 8'h00, v);
      repeat (4) begin
         r = $urandom;
         wrr(asx_pkg::ADDR_EXT1, r[7:0]);
         rdr(asx_pkg::ADDR_EXT1); chk("ext1", r[7:0] & 8'h3d, v);
      end
      wrr(asx_pkg::ADDR_EXT1, 8'h00);
      // carrier loss with auto enable
      csel <= 1'b1; wrr(asx_pkg::ADDR_IRQ_MSK, 8'h03);
      cneg <= 1'b1; cyc(6);
      chk("rx_reset", 2'b01, rxr);
      chk("irq", 1'b1, irq);
      rdr(asx_pkg::ADDR_CHANNEL0_STATUS_REG); chk("carrier", 1'b1, v[2]);
      rdr(asx_pkg::ADDR_IRQ_ST); chk("carrier_rise", 1'b1, v[0]);
      cyc(1); chk("irq", 1'b0, irq);
      wrr(asx_pkg::ADDR_EXT0, 8'h40); cyc(2);
      chk("rx_reset", 2'b00, rxr);
      cneg <= 1'b0; cyc(6);
      rdr(asx_pkg::ADDR_CHANNEL0_STATUS_REG); rdr(asx_pkg::ADDR_CHANNEL0_STATUS_REG);
      chk("carrier", 1'b0, v[2]);
      // clear to send negated
      tsel <= 1'b1; thei <= 2'b11; tneg <= 1'b1;
      wrr(asx_pkg::ADDR_EXT0, 8'h00); cyc(5);
      chk("tx_empty", 2'b10, the);
      rdr(asx_pkg::ADDR_CHANNEL0_STATUS_REG); chk("stat_empty", 1'b0, v[1]);
      wrr(asx_pkg::ADDR_EXT0, 8'h20); cyc(3);
      chk("tx_empty", 2'b11, the);
      rdr(asx_pkg::ADDR_CTLB0); chk("cts_level", 1'b1, v[5]);
      tneg <= 1'b0;
      // send break needs both bits
      foreach (brk[i]) begin
         r = $urandom;
         txs <= r[1:0];
         wrr(asx_pkg::ADDR_EXT0, brk[i]);
         repeat (8) @(posedge clk);
         #1 chk("tx_out", {r[1], (brk[i] == 8'h05) ? 1'b0 : r[0]}, txo);
      end
      // break detect, then each way of clearing it
      wrr(asx_pkg::ADDR_EXT0, 8'h00); head(1'b1, 1'b1);
      rdr(asx_pkg::ADDR_EXT0); chk("brk_off", 1'b0, v[1]);
      wrr(asx_pkg::ADDR_EXT0, 8'h04); head(1'b0, 1'b1);
      rdr(asx_pkg::ADDR_EXT0); chk("brk_nonzero", 1'b0, v[1]);
      for (int m = 0; m < 3; m++) begin
         head(1'b1, 1'b1);
         rdr(asx_pkg::ADDR_EXT0); chk("brk_det", 1'b1, v[1]);
         if (m == 0) wrr(asx_pkg::ADDR_CTLA, 8'h00);
         else if (m == 1) begin
            io_stop_mode <= 1'b1; cyc(2); io_stop_mode <= 1'b0;
         end else begin
            cneg <= 1'b1; cyc(6); cneg <= 1'b0; cyc(4);
         end
         rdr(asx_pkg::ADDR_EXT0); chk("brk_clr", 1'b0, v[1]);
      end
      rdr(asx_pkg::ADDR_IRQ_ST); chk("brk_irq", 1'b1, v[1]);
      // reset in mid run clears every extension bit and break detect
      head(1'b1, 1'b1); wrr(asx_pkg::ADDR_EXT1, 8'h3d);
      rst <= 1'b1; cyc(2); rst <= 1'b0;
      rdr(asx_pkg::ADDR_EXT0); chk("ext0", 8'h00, v);
      rdr(asx_pkg::ADDR_EXT1); chk("ext1", 8'h00, v);
      // bit time for each setting in the period table
      wrr(asx_pkg::ADDR_TC0, 8'h00); wrr(asx_pkg::ADDR_TC0, 8'h03);
      foreach (tcb[i]) begin
         run <= (tcb[i][2:0] == 3'h7);
         wrr(asx_pkg::ADDR_CTLB0, tcb[i]);
         wrr(asx_pkg::ADDR_EXT0, tex[i]);
         gap(n); gap(n);
         chk("bit_time", per(tcb[i], tex[i], 3), n);
         // generator level flips once per half period
         if (tcb[i][2:0] != 3'h7) begin
            v[0] = baud_generator[0]; cyc(per(tcb[i], tex[i] | 8'h10, 3) / 2);
            chk("brg_clk", !v[0], baud_generator[0]);
         end
      end
      close_out;
   end
endmodule
